// ### inc/pldmi_pkg.sv
// pldmi_pkg: constants, register map and carriers of the decode and logic arrays
// assumes: one 100 MHz clock, AHB-Lite register access, pins sampled by the top
`default_nettype none
package pldmi_pkg;
    // array input bus
    localparam int NIN      = 66;
    localparam int POS_ADDR = 0;
    localparam int POS_BUS_CONTROL_INPUTS = 16;
    localparam int POS_RST  = 19;
    localparam int POS_PDN  = 20;
    localparam int POS_GP   = 21;
    localparam int POS_PD   = 45;
    localparam int POS_PF   = 49;
    localparam int POS_PAGE = 57;
    localparam int POS_RDY  = 65;
    localparam int ADDR_W   = 16;
    localparam int ADDR_PIN_W = 20;
    localparam int BURST_ADDR_LSB = 4;

    // array sizes
    localparam int N_MAIN     = 8;
    localparam int N_BOOT     = 4;
    localparam int SEL_PT     = 3;
    localparam int N_GP       = 24;
    localparam int BASE_MAIN  = 0;
    localparam int BASE_BOOT  = N_MAIN * SEL_PT;
    localparam int BASE_SRAM  = BASE_BOOT + N_BOOT * SEL_PT;
    localparam int BASE_REGSP = BASE_SRAM + SEL_PT;
    localparam int DEC_PT     = BASE_REGSP + 1;
    localparam int NPT        = DEC_PT + 100;
    localparam int PT_IDX_W   = 8;

    // register byte offsets
    localparam logic [7:0] OFS_MEM_SIZE  = 8'h00;
    localparam logic [7:0] OFS_BOOT_CODE = 8'h04;
    localparam logic [7:0] OFS_PMR0      = 8'h08;
    localparam logic [7:0] OFS_PMR2      = 8'h0C;
    localparam logic [7:0] OFS_MODE      = 8'h10;
    localparam logic [7:0] OFS_GP_OE     = 8'h14;
    localparam logic [7:0] OFS_ALLOC     = 8'h18;
    localparam logic [7:0] OFS_PAGE      = 8'h1C;
    localparam logic [7:0] OFS_TRUE0     = 8'h20;
    localparam logic [7:0] OFS_TRUE1     = 8'h24;
    localparam logic [7:0] OFS_TRUE2     = 8'h28;
    localparam logic [7:0] OFS_COMP0     = 8'h2C;
    localparam logic [7:0] OFS_COMP1     = 8'h30;
    localparam logic [7:0] OFS_COMP2     = 8'h34;
    localparam logic [7:0] OFS_COMMIT    = 8'h38;
    localparam logic [7:0] OFS_STATUS    = 8'h3C;
    localparam logic [7:0] OFS_SELECTS   = 8'h40;

    // fields and reset values
    localparam int PMR0_FAST_BIT = 3;
    localparam int N_BLOCK       = 5;
    localparam int MODE_BURST_BIT = 0;
    localparam logic [7:0]  PMR0_RESET  = 8'h08;
    localparam logic [23:0] ALLOC_VALID = 24'hFFFFFE;
    localparam logic [3:0]  FLASH_CODE_DEFAULT = 4'h1;
    localparam logic [3:0]  SRAM_CODE_DEFAULT  = 4'h1;
    localparam logic [3:0]  BOOT_SIZE_DEFAULT  = 4'h1;
    localparam logic [1:0]  BOOT_TYPE_DEFAULT  = 2'h0;
    // both polarities of every input set: term reads false until programmed
    localparam logic [NIN-1:0] PT_MASK_RESET = {NIN{1'b1}};

    // standby idle time, a least time so rounded up
    localparam int CLK_PERIOD_PS = 10000;
    localparam int STANDBY_NS    = 70;
    localparam int STANDBY_CYC   = (STANDBY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    typedef logic [NIN-1:0] pldmi_bus_t;

    typedef struct packed {
        logic [ADDR_PIN_W-1:0] addr;
        logic [2:0]            bus_control_inputs;
        logic                  rst;
        logic                  power_down_input;
        logic [N_GP-1:0]       gp_in;
        logic [3:0]            pd;
        logic [7:0]            pf;
        logic                  rdy;
    } pldmi_pin_s;

    typedef struct packed {
        logic [N_MAIN-1:0] main_sector_select;
        logic [N_BOOT-1:0] boot_sector_select;
        logic              sram_select;
        logic              register_space_select;
    } pldmi_sel_s;

    function automatic int gp_pt_count(input int i);
        if (i < 4) return 3;
        else if (i < 8) return 9;
        else if (i < 12) return 4;
        else if (i < 16) return 7;
        else return 1;
    endfunction : gp_pt_count

    function automatic int gp_pt_base(input int i);
        int s;
        s = DEC_PT;
        for (int k = 0; k < i; k++) s += gp_pt_count(k);
        return s;
    endfunction : gp_pt_base
endpackage : pldmi_pkg
`default_nettype wire

// ### core/pldmi_term.sv
// pldmi_term: one product term with its own programmable true and complement masks
// assumes: masks loaded by a one-cycle load pulse from the register block
`default_nettype none
module pldmi_term (
    input  wire logic                     ref_clk,
    input  wire logic                     rst_n,
    input  wire logic                     load,
    input  wire pldmi_pkg::pldmi_bus_t    true_in,
    input  wire pldmi_pkg::pldmi_bus_t    comp_in,
    input  wire pldmi_pkg::pldmi_bus_t    bus,
    output logic                          term
);
    typedef struct packed {
        pldmi_pkg::pldmi_bus_t tmask;
        pldmi_pkg::pldmi_bus_t cmask;
    } pldmi_term_state_s;

    pldmi_term_state_s s_q;
    pldmi_term_state_s s_d;

    always_comb begin
        s_d = s_q;
        if (load) begin
            s_d.tmask = true_in;
            s_d.cmask = comp_in;
        end
    end

    // configuration survives everything except reset, which restores the image
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s_q.tmask <= pldmi_pkg::PT_MASK_RESET;
            s_q.cmask <= pldmi_pkg::PT_MASK_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // and of every selected input in true and complement form
    assign term = &(~s_q.tmask | bus) & &(~s_q.cmask | ~bus);
endmodule : pldmi_term
`default_nettype wire

// ### core/pldmi_top.sv
// pldmi_top: decode array, general logic array and memory id registers
// assumes: pins from outside the clock domain, an AHB-Lite master as sole bus owner
//
// Implementation choices: the AHB-Lite slave port and the register offsets.
`default_nettype none
module pldmi_top #(
    parameter logic [3:0] FLASH_SIZE_CODE = pldmi_pkg::FLASH_CODE_DEFAULT,
    parameter logic [3:0] SRAM_SIZE_CODE  = pldmi_pkg::SRAM_CODE_DEFAULT,
    parameter logic [3:0] BOOT_SIZE_CODE  = pldmi_pkg::BOOT_SIZE_DEFAULT,
    parameter logic [1:0] BOOT_TYPE_CODE  = pldmi_pkg::BOOT_TYPE_DEFAULT
) (
    input  wire logic                      ref_clk,
    input  wire logic                      rst_n,
    input  wire logic                      hsel,
    input  wire logic [31:0]               haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic [31:0]               hwdata,
    input  wire logic                      hready,
    output logic                           hreadyout,
    output logic                           hresp,
    output logic [31:0]                    hrdata,
    input  wire pldmi_pkg::pldmi_pin_s     pins_in,
    output pldmi_pkg::pldmi_sel_s          selects,
    output logic [pldmi_pkg::N_GP-1:0]     gp_out,
    output logic [pldmi_pkg::N_GP-1:0]     gp_oe,
    output logic                           array_standby
);
    typedef struct packed {
        pldmi_pkg::pldmi_pin_s              sync1;
        pldmi_pkg::pldmi_pin_s              sync2;
        pldmi_pkg::pldmi_bus_t              last_bus;
        logic [3:0]                         idle_cnt;
        logic                               standby;
        logic [7:0]                         pmr0;
        logic [pldmi_pkg::N_BLOCK-1:0]      pmr2;
        logic                               burst;
        logic [pldmi_pkg::N_GP-1:0]         gp_oe;
        logic [pldmi_pkg::N_GP-1:0]         alloc;
        logic [7:0]                         page;
        pldmi_pkg::pldmi_bus_t              tmask;
        pldmi_pkg::pldmi_bus_t              cmask;
        logic                               wr_pend;
        logic [7:0]                         addr;
        logic [31:0]                        rdata;
        pldmi_pkg::pldmi_sel_s              sel;
        logic [pldmi_pkg::N_GP-1:0]         gp;
    } pldmi_state_s;

    localparam logic [3:0] STANDBY_CNT = 4'(pldmi_pkg::STANDBY_CYC);

    pldmi_state_s                      s_q;
    pldmi_state_s                      s_d;
    pldmi_pkg::pldmi_bus_t             bus;
    logic [pldmi_pkg::NPT-1:0]         terms;
    logic [pldmi_pkg::NPT-1:0]         pt_load;
    logic [pldmi_pkg::N_GP-1:0]        gp_own;
    logic [pldmi_pkg::N_MAIN-1:0]      main_raw;
    logic [pldmi_pkg::N_BOOT-1:0]      boot_raw;
    logic                              sram_raw;
    logic                              regsp_raw;
    logic                              addr_ok;
    logic                              commit;

    function automatic logic [31:0] read_word(input logic [7:0] a, input pldmi_state_s st);
        logic [31:0] w;
        w = '0;
        unique case (a)
            pldmi_pkg::OFS_MEM_SIZE:  w = {24'h000000, SRAM_SIZE_CODE, FLASH_SIZE_CODE};
            pldmi_pkg::OFS_BOOT_CODE: w = {24'h000000, 2'h0, BOOT_TYPE_CODE, BOOT_SIZE_CODE};
            pldmi_pkg::OFS_PMR0:      w = {24'h000000, st.pmr0};
            pldmi_pkg::OFS_PMR2:      w = {27'h0000000, st.pmr2};
            pldmi_pkg::OFS_MODE:      w = {31'h00000000, st.burst};
            pldmi_pkg::OFS_GP_OE:     w = {8'h00, st.gp_oe};
            pldmi_pkg::OFS_ALLOC:     w = {8'h00, st.alloc};
            pldmi_pkg::OFS_PAGE:      w = {24'h000000, st.page};
            pldmi_pkg::OFS_TRUE0:     w = st.tmask[31:0];
            pldmi_pkg::OFS_TRUE1:     w = st.tmask[63:32];
            pldmi_pkg::OFS_TRUE2:     w = {30'h00000000, st.tmask[65:64]};
            pldmi_pkg::OFS_COMP0:     w = st.cmask[31:0];
            pldmi_pkg::OFS_COMP1:     w = st.cmask[63:32];
            pldmi_pkg::OFS_COMP2:     w = {30'h00000000, st.cmask[65:64]};
            pldmi_pkg::OFS_STATUS:    w = {30'h00000000, st.pmr0[pldmi_pkg::PMR0_FAST_BIT], st.standby};
            pldmi_pkg::OFS_SELECTS:   w = {18'h00000, st.sel};
            default:                  w = '0;
        endcase
        return w;
    endfunction : read_word

    // input bus assembled from the second synchroniser stage and the page register
    always_comb begin
        bus = '0;
        bus[pldmi_pkg::POS_ADDR +: pldmi_pkg::ADDR_W] = s_q.burst
            ? s_q.sync2.addr[pldmi_pkg::BURST_ADDR_LSB +: pldmi_pkg::ADDR_W]
            : s_q.sync2.addr[pldmi_pkg::ADDR_W-1:0];
        // blocked controls read as zero; unused-only is software's duty
        bus[pldmi_pkg::POS_BUS_CONTROL_INPUTS +: 3] = s_q.sync2.bus_control_inputs & ~s_q.pmr2[2:0];
        bus[pldmi_pkg::POS_RST]       = s_q.sync2.rst & ~s_q.pmr2[3];
        bus[pldmi_pkg::POS_PDN]       = s_q.sync2.power_down_input & ~s_q.pmr2[4];
        // pin reads back its own level, so an output pin also feeds back
        bus[pldmi_pkg::POS_GP +: pldmi_pkg::N_GP] = s_q.sync2.gp_in;
        bus[pldmi_pkg::POS_PD +: 4]   = s_q.sync2.pd;
        bus[pldmi_pkg::POS_PF +: 8]   = s_q.sync2.pf;
        bus[pldmi_pkg::POS_PAGE +: 8] = s_q.page;
        bus[pldmi_pkg::POS_RDY]       = s_q.sync2.rdy;
    end

    assign addr_ok = s_q.wr_pend;
    assign commit  = addr_ok && (s_q.addr == pldmi_pkg::OFS_COMMIT);

    genvar gi;
    generate
        for (gi = 0; gi < pldmi_pkg::NPT; gi++) begin : g_pt
            assign pt_load[gi] = commit && (hwdata[pldmi_pkg::PT_IDX_W-1:0] == pldmi_pkg::PT_IDX_W'(gi));
            pldmi_term u_term (
                .ref_clk (ref_clk),
                .rst_n   (rst_n),
                .load    (pt_load[gi]),
                .true_in (s_q.tmask),
                .comp_in (s_q.cmask),
                .bus     (bus),
                .term    (terms[gi])
            );
        end
        for (gi = 0; gi < pldmi_pkg::N_MAIN; gi++) begin : g_main
            assign main_raw[gi] = |terms[pldmi_pkg::BASE_MAIN + gi*pldmi_pkg::SEL_PT +: pldmi_pkg::SEL_PT];
        end
        for (gi = 0; gi < pldmi_pkg::N_BOOT; gi++) begin : g_boot
            assign boot_raw[gi] = |terms[pldmi_pkg::BASE_BOOT + gi*pldmi_pkg::SEL_PT +: pldmi_pkg::SEL_PT];
        end
        for (gi = 0; gi < pldmi_pkg::N_GP; gi++) begin : g_gp
            assign gp_own[gi] = |terms[pldmi_pkg::gp_pt_base(gi) +: pldmi_pkg::gp_pt_count(gi)];
        end
    endgenerate

    assign sram_raw  = |terms[pldmi_pkg::BASE_SRAM +: pldmi_pkg::SEL_PT];
    assign regsp_raw = terms[pldmi_pkg::BASE_REGSP];

    always_comb begin
        logic sram_or_io;
        logic any_boot;
        s_d = s_q;
        sram_or_io = sram_raw | regsp_raw;
        any_boot   = |boot_raw;

        s_d.sync1 = pins_in;
        s_d.sync2 = s_q.sync1;

        // idle detection; the arrays stay combinational, only the flag moves
        if (bus != s_q.last_bus) begin
            s_d.idle_cnt = '0;
        end else if (s_q.idle_cnt < STANDBY_CNT) begin
            s_d.idle_cnt = s_q.idle_cnt + 4'h1;
        end
        s_d.last_bus = bus;
        s_d.standby  = !s_q.pmr0[pldmi_pkg::PMR0_FAST_BIT]
                       && (bus == s_q.last_bus) && (s_d.idle_cnt >= STANDBY_CNT);

        // sram or register space select gates the memory alone, with no flash below it
        s_d.sel.sram_select           = sram_raw;
        s_d.sel.register_space_select = regsp_raw;
        s_d.sel.boot_sector_select    = boot_raw & {pldmi_pkg::N_BOOT{~sram_or_io}};
        s_d.sel.main_sector_select    = main_raw & {pldmi_pkg::N_MAIN{~sram_or_io & ~any_boot}};

        // output i lends its terms to output i-1 while alloc bit i is set
        for (int i = 0; i < pldmi_pkg::N_GP; i++) begin
            s_d.gp[i] = gp_own[i] & ~s_q.alloc[i];
            if (i < pldmi_pkg::N_GP - 1) begin
                s_d.gp[i] = s_d.gp[i] | (gp_own[i+1] & s_q.alloc[i+1]);
            end
        end

        // data phase of a write
        if (s_q.wr_pend) begin
            unique case (s_q.addr)
                pldmi_pkg::OFS_PMR0:  s_d.pmr0  = hwdata[7:0];
                pldmi_pkg::OFS_PMR2:  s_d.pmr2  = hwdata[pldmi_pkg::N_BLOCK-1:0];
                pldmi_pkg::OFS_MODE:  s_d.burst = hwdata[pldmi_pkg::MODE_BURST_BIT];
                pldmi_pkg::OFS_GP_OE: s_d.gp_oe = hwdata[pldmi_pkg::N_GP-1:0];
                pldmi_pkg::OFS_ALLOC: s_d.alloc = hwdata[pldmi_pkg::N_GP-1:0] & pldmi_pkg::ALLOC_VALID;
                pldmi_pkg::OFS_PAGE:  s_d.page  = hwdata[7:0];
                pldmi_pkg::OFS_TRUE0: s_d.tmask[31:0]  = hwdata;
                pldmi_pkg::OFS_TRUE1: s_d.tmask[63:32] = hwdata;
                pldmi_pkg::OFS_TRUE2: s_d.tmask[65:64] = hwdata[1:0];
                pldmi_pkg::OFS_COMP0: s_d.cmask[31:0]  = hwdata;
                pldmi_pkg::OFS_COMP1: s_d.cmask[63:32] = hwdata;
                pldmi_pkg::OFS_COMP2: s_d.cmask[65:64] = hwdata[1:0];
                // id registers, commit, status and unmapped: nothing stored
                default: s_d.wr_pend = 1'b0;
            endcase
        end

        // address phase; read data taken from next state so a write just ahead is seen
        s_d.wr_pend = 1'b0;
        s_d.rdata   = '0;
        if (hsel && htrans[1] && hready) begin
            s_d.addr    = haddr[7:0];
            s_d.wr_pend = hwrite;
            if (!hwrite) begin
                s_d.rdata = read_word(haddr[7:0], s_d);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s_q       <= '0;
            s_q.pmr0  <= pldmi_pkg::PMR0_RESET;
            s_q.tmask <= pldmi_pkg::PT_MASK_RESET;
            s_q.cmask <= pldmi_pkg::PT_MASK_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // zero wait states: every transfer completes in its first data cycle
    assign hreadyout     = 1'b1;
    assign hresp         = 1'b0;
    assign hrdata        = s_q.rdata;
    assign selects       = s_q.sel;
    assign gp_out        = s_q.gp;
    assign gp_oe         = s_q.gp_oe;
    assign array_standby = s_q.standby;
endmodule : pldmi_top
`default_nettype wire

// ### verif/pldmi_top_assertions.sv
// pldmi_top_assertions: bus answer, id value, priority and standby checks
// assumes: bound to pldmi_top, one clock, zero-wait register slave
`default_nettype none
module pldmi_top_assertions #(
    parameter logic [3:0] FLASH_SIZE_CODE = 4'h1,
    parameter logic [3:0] SRAM_SIZE_CODE  = 4'h1,
    parameter logic [3:0] BOOT_SIZE_CODE  = 4'h1,
    parameter logic [1:0] BOOT_TYPE_CODE  = 2'h0
) (
    input wire logic                  ref_clk,
    input wire logic                  rst_n,
    input wire logic                  hsel,
    input wire logic [31:0]           haddr,
    input wire logic [1:0]            htrans,
    input wire logic                  hwrite,
    input wire logic                  hready,
    input wire logic                  hreadyout,
    input wire logic                  hresp,
    input wire logic [31:0]           hrdata,
    input wire pldmi_pkg::pldmi_pin_s pins_in,
    input wire pldmi_pkg::pldmi_sel_s selects,
    input wire logic                  array_standby
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // cycles the pins have held still, saturating
    logic [3:0] calm_q;
    always_ff @(posedge ref_clk) begin
        if (!rst_n || $changed(pins_in)) calm_q <= 4'h0;
        else if (calm_q != 4'hF) calm_q <= calm_q + 4'h1;
    end
    sequence rd_at(logic [7:0] ofs);
        hsel && htrans[1] && hready && !hwrite && haddr == {24'h0, ofs};
    endsequence
    chk_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer not ready okay");
    chk_id0_value: assert property (rd_at(pldmi_pkg::OFS_MEM_SIZE) |=>
        hrdata == {24'h0, SRAM_SIZE_CODE, FLASH_SIZE_CODE}) else $error("memory size code wrong");
    chk_id1_value: assert property (rd_at(pldmi_pkg::OFS_BOOT_CODE) |=>
        hrdata == {26'h0, BOOT_TYPE_CODE, BOOT_SIZE_CODE}) else $error("boot block code wrong");
    chk_unmapped_zero: assert property (rd_at(8'h44) |=> hrdata == 32'h0) else $error("unmapped read not zero");
    chk_rdata_idle: assert property (!(hsel && htrans[1] && hready && !hwrite) |=> hrdata == 32'h0)
        else $error("read data outside data phase");
    chk_sram_wins: assert property ((selects.sram_select || selects.register_space_select) |->
        selects.main_sector_select == 8'h0 && selects.boot_sector_select == 4'h0) else $error("flash beat sram");
    chk_boot_wins: assert property (|selects.boot_sector_select |->
        selects.main_sector_select == 8'h0) else $error("main beat boot sector");
    chk_standby_calm: assert property ($rose(array_standby) |-> $past(calm_q, 4) >= 4'h2)
        else $error("standby while pins moving");
    chk_standby_drop: assert property (array_standby && $changed(pins_in) |-> ##[1:5] !array_standby)
        else $error("standby kept after input change");
endmodule : pldmi_top_assertions
`default_nettype wire

// ### verif/pldmi_host_model.sv
// pldmi_host_model: host side that puts address, control and port levels on the pins
// assumes: bench requests change just after an edge; slow delays by one more cycle
`default_nettype none
module pldmi_host_model (
    input  wire logic                  ref_clk,
    input  wire pldmi_pkg::pldmi_pin_s req,
    input  wire logic                  slow,
    output var pldmi_pkg::pldmi_pin_s  pins
);
    pldmi_pkg::pldmi_pin_s hold_q;
    initial pins = '0;
    // full bus incl. high address for burst hosts and port inputs for decode
    always @(posedge ref_clk) begin
        hold_q <= req;
        pins   <= slow ? hold_q : req;
    end
endmodule : pldmi_host_model
`default_nettype wire

// ### verif/pldmi_top_tb.sv
// pldmi_top_tb: self-checking bench of the arrays and id registers
// assumes: pldmi_pkg, pldmi_top, the host model and the checker compiled first
`default_nettype none
module pldmi_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [3:0] FLASH_C = 4'h5;
    localparam logic [3:0] SRAM_C  = 4'h3;
    localparam logic [3:0] BOOT_C  = 4'h2;
    localparam logic [1:0] TYPE_C  = 2'h1;
    logic ref_clk = 1'b0;
    logic rst_n   = 1'b0;
    logic hsel    = 1'b0;
    logic hwrite  = 1'b0;
    logic slow    = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr  = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic        hresp;
    logic        array_standby;
    logic [23:0] gp_out;
    logic [23:0] gp_oe;
    wire logic   hready;
    pldmi_pkg::pldmi_pin_s req = '0;
    pldmi_pkg::pldmi_pin_s pins;
    pldmi_pkg::pldmi_sel_s selects;
    int err_total  = 0;
    int n_compared = 0;

    pldmi_top #(.FLASH_SIZE_CODE(FLASH_C), .SRAM_SIZE_CODE(SRAM_C), .BOOT_SIZE_CODE(BOOT_C),
        .BOOT_TYPE_CODE(TYPE_C)) DUT (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .pins_in(pins), .selects(selects),
        .gp_out(gp_out), .gp_oe(gp_oe), .array_standby(array_standby));
    pldmi_host_model u_host (.ref_clk(ref_clk), .req(req), .slow(slow), .pins(pins));

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    // one single transfer; the slave answers when it likes
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge ref_clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge ref_clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : xfer

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        cmp(rd, exp);
    endtask : rdchk

    task automatic selchk(input logic [13:0] exp);
        // selects trail a register write by one edge, seen one edge later
        repeat (2) @(posedge ref_clk);
        cmp({18'h0, selects}, {18'h0, exp});
        rdchk(pldmi_pkg::OFS_SELECTS, {18'h0, exp});
    endtask : selchk

    task automatic setpins(input pldmi_pkg::pldmi_pin_s p);
        @(posedge ref_clk);
        req <= p;
        repeat (7) @(posedge ref_clk);
    endtask : setpins

    function automatic logic [65:0] b(input int i);
        return 66'h1 << i;
    endfunction : b

    task automatic prog(input logic [31:0] idx, input logic [65:0] t, input logic [65:0] c);
        xfer(pldmi_pkg::OFS_TRUE0, 1'b1, t[31:0]);
        xfer(pldmi_pkg::OFS_TRUE1, 1'b1, t[63:32]);
        xfer(pldmi_pkg::OFS_TRUE2, 1'b1, {30'h0, t[65:64]});
        xfer(pldmi_pkg::OFS_COMP0, 1'b1, c[31:0]);
        xfer(pldmi_pkg::OFS_COMP1, 1'b1, c[63:32]);
        xfer(pldmi_pkg::OFS_COMP2, 1'b1, {30'h0, c[65:64]});
        xfer(pldmi_pkg::OFS_COMMIT, 1'b1, idx);
    endtask : prog

    task automatic test_ids;
        rdchk(pldmi_pkg::OFS_MEM_SIZE, {24'h0, SRAM_C, FLASH_C});
        xfer(pldmi_pkg::OFS_MEM_SIZE, 1'b1, 32'hFFFFFFFF);
        xfer(pldmi_pkg::OFS_BOOT_CODE, 1'b1, 32'hFFFFFFFF);
        rdchk(pldmi_pkg::OFS_MEM_SIZE, {24'h0, SRAM_C, FLASH_C});
        rdchk(pldmi_pkg::OFS_BOOT_CODE, {26'h0, TYPE_C, BOOT_C});
        rdchk(8'h44, 32'h0);
        rdchk(pldmi_pkg::OFS_PMR0, 32'h00000008);
        selchk(14'h0000);
        $display("test_ids done");
    endtask : test_ids

    task automatic test_decode;
        pldmi_pkg::pldmi_pin_s p;
        logic [19:0] ad [4] = '{20'h08000, 20'h0A000, 20'h0E000, 20'h00000};
        logic [13:0] ex [4] = '{14'h0040, 14'h0004, 14'h0002, 14'h0000};
        p = '0;
        prog(32'd0, b(15), '0);
        prog(32'd24, b(15) | b(13), '0);
        prog(32'd36, b(15) | b(14), '0);
        prog(32'd39, b(57), b(15));
        prog(32'd37, b(16), '0);
        for (int i = 0; i < 4; i++) begin
            p.addr = ad[i];
            setpins(p);
            selchk(ex[i]);
        end
        xfer(pldmi_pkg::OFS_PAGE, 1'b1, 32'h1);
        selchk(14'h0001);
        xfer(pldmi_pkg::OFS_PAGE, 1'b1, 32'h0);
        p.bus_control_inputs = 3'h1;
        setpins(p);
        selchk(14'h0002);
        xfer(pldmi_pkg::OFS_PMR2, 1'b1, 32'h1);
        selchk(14'h0000);
        xfer(pldmi_pkg::OFS_PMR2, 1'b1, 32'h0);
        p = '0;
        p.addr = 20'h80000;
        setpins(p);
        selchk(14'h0000);
        xfer(pldmi_pkg::OFS_MODE, 1'b1, 32'h1);
        selchk(14'h0040);
        xfer(pldmi_pkg::OFS_MODE, 1'b1, 32'h0);
        $display("test_decode done");
    endtask : test_decode

    task automatic test_gp;
        pldmi_pkg::pldmi_pin_s p;
        p = '0;
        // output 0 on port b pin 0, output 16 (first of port c) on pd0
        prog(32'd40, b(29), '0);
        prog(32'd132, b(45), '0);
        prog(32'd43, b(49), '0);
        xfer(pldmi_pkg::OFS_GP_OE, 1'b1, 32'h00FFFFFF);
        p.gp_in = 24'h000100;
        p.pd = 4'h1;
        setpins(p);
        cmp({8'h0, gp_out}, 32'h00010001);
        cmp({8'h0, gp_oe}, 32'h00FFFFFF);
        rdchk(pldmi_pkg::OFS_GP_OE, 32'h00FFFFFF);
        p = '0;
        p.pf = 8'h01;
        setpins(p);
        cmp({8'h0, gp_out}, 32'h00000002);
        xfer(pldmi_pkg::OFS_ALLOC, 1'b1, 32'h2);
        repeat (3) @(posedge ref_clk);
        cmp({8'h0, gp_out}, 32'h00000001);
        $display("test_gp done");
    endtask : test_gp

    task automatic test_standby;
        pldmi_pkg::pldmi_pin_s p;
        p = '0;
        slow <= 1'b1;
        xfer(pldmi_pkg::OFS_PMR0, 1'b1, 32'h0);
        repeat (12) @(posedge ref_clk);
        cmp({31'h0, array_standby}, 32'h1);
        rdchk(pldmi_pkg::OFS_STATUS, 32'h1);
        p.addr = 20'h00010;
        setpins(p);
        cmp({31'h0, array_standby}, 32'h0);
        xfer(pldmi_pkg::OFS_PMR0, 1'b1, 32'h8);
        repeat (12) @(posedge ref_clk);
        cmp({31'h0, array_standby}, 32'h0);
        slow <= 1'b0;
        $display("test_standby done");
    endtask : test_standby

    initial begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        end_of_test();
    end

    initial begin
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        test_ids();
        test_decode();
        test_gp();
        test_standby();
        end_of_test();
    end
endmodule : pldmi_top_tb

bind pldmi_top pldmi_top_assertions #(.FLASH_SIZE_CODE(FLASH_SIZE_CODE), .SRAM_SIZE_CODE(SRAM_SIZE_CODE),
    .BOOT_SIZE_CODE(BOOT_SIZE_CODE), .BOOT_TYPE_CODE(BOOT_TYPE_CODE)) u_chk (.ref_clk(ref_clk),
    .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pins_in(pins_in), .selects(selects),
    .array_standby(array_standby));
`default_nettype wire
